//--- common/time_sync_pkg.sv
package time_sync_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_IDENT      = 8'h00;
	localparam logic [7:0] OFS_CONTROL    = 8'h04;
	localparam logic [7:0] OFS_REF_SEL    = 8'h08;
	localparam logic [7:0] OFS_PUSH       = 8'h0c;
	localparam logic [7:0] OFS_LOAD_VAL   = 8'h10;
	localparam logic [7:0] OFS_LOAD_STB   = 8'h14;
	localparam logic [7:0] OFS_CMP_VAL    = 8'h18;
	localparam logic [7:0] OFS_CMP_LEN    = 8'h1c;
	localparam logic [7:0] OFS_IRQ_RAW    = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASKED = 8'h24;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h28;
	localparam logic [7:0] OFS_EV_POP     = 8'h30;
	localparam logic [7:0] OFS_EV_LOW     = 8'h34;
	localparam logic [7:0] OFS_EV_MID     = 8'h38;
	localparam logic [7:0] OFS_EV_HIGH    = 8'h3c;
	// field positions and widths
	localparam int CTRL_EN_BIT   = 0;
	localparam int PUSH_BIT      = 0;
	localparam int LOAD_STB_BIT  = 0;
	localparam int POP_BIT       = 0;
	localparam int PEND_BIT      = 0;
	localparam int REF_SEL_W     = 5;
	localparam int CMP_LEN_W     = 16;
	localparam int EV_TYPE_W     = 4;
	localparam int EV_TYPE_LSB   = 20;
	// identity fields, values arbitrary
	localparam logic [15:0] UNIT_IDENT     = 16'h5a5a;
	localparam logic [4:0]  RTL_REVISION   = 5'h01;
	localparam logic [2:0]  MAJOR_REVISION = 3'h1;
	localparam logic [7:0]  MINOR_REVISION = 8'h00;
	// reset value and counter limits
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] CNT_MAX  = 32'hffff_ffff;
	localparam logic [31:0] CNT_HALF = 32'h7fff_ffff;
	// event types
	localparam logic [3:0] EV_PUSH     = 4'h0;
	localparam logic [3:0] EV_ROLL     = 4'h1;
	localparam logic [3:0] EV_HALF     = 4'h2;
	localparam logic [3:0] EV_RX       = 4'h4;
	localparam logic [3:0] EV_TX       = 4'h5;
	localparam logic [3:0] EV_COMPARE  = 4'h6;
	// event fifo
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW    = 3;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- core/time_sync_timestamp_unit.sv
`timescale 1ns/10ps
// Summary of operation
// - unit enable low holds counter, compare and reference logic in reset
// - five-bit select field drives the external reference clock multiplexer
// - select field is writable only while the unit is disabled
// - writing one to push bit queues a software stamp event
// - pushed event carries the counter value at the write
// - push bit is write-only and reads zero
// - load strobe copies the 32-bit load value into the counter
// - load value register reads back last written value
// - load strobe is write-only and self-clears after one clock
// - compare output held for exactly length reference periods on match
// - comparison event raised when counter becomes equal to compare value
// - non-zero length enables compare event and output, zero disables both
// - events read as low, middle and high words at consecutive offsets
// - raw pending reads one while the event fifo holds events
// - masked pending is raw pending gated by interrupt enable
// - pop discards the head event and advances the next
// - event types: push 0000, roll 0001, half 0010, compare 0110
module time_sync_timestamp_unit
	import time_sync_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// time reference
	input  wire logic        selected_time_reference,
	output logic [4:0]       ref_clock_select,
	output logic             compare_output
);

	logic                 sync_unit_enable_r;
	logic [REF_SEL_W-1:0] ref_sel_r;
	logic [31:0]          load_val_r;
	logic [31:0]          cmp_val_r;
	logic [CMP_LEN_W-1:0] cmp_len_r;
	logic                 irq_en_r;
	logic [31:0]          cnt_r;
	logic [31:0]          cnt_nxt;
	logic [CMP_LEN_W-1:0] pulse_cnt_r;
	logic [CMP_LEN_W-1:0] pulse_cnt_nxt;
	logic                 bvalid_r;
	logic [1:0]           bresp_r;
	logic                 rvalid_r;
	logic [1:0]           rresp_r;
	logic [31:0]          rdata_r;
	logic [31:0]          ev_stamp_mem [FIFO_DEPTH];
	logic [3:0]           ev_type_mem  [FIFO_DEPTH];
	logic [FIFO_AW-1:0]   wr_ptr_r;
	logic [FIFO_AW-1:0]   rd_ptr_r;
	logic [FIFO_AW:0]     count_r;
	logic [FIFO_AW:0]     count_nxt;

	function automatic logic known_addr(input logic [7:0] a);
		unique case (a)
			OFS_IDENT, OFS_CONTROL, OFS_REF_SEL, OFS_PUSH, OFS_LOAD_VAL,
			OFS_LOAD_STB, OFS_CMP_VAL, OFS_CMP_LEN, OFS_IRQ_RAW,
			OFS_IRQ_MASKED, OFS_IRQ_EN, OFS_EV_POP, OFS_EV_LOW,
			OFS_EV_MID, OFS_EV_HIGH: known_addr = 1'b1;
			default: known_addr = 1'b0;
		endcase
	endfunction

	// write channel: both address and data taken in one beat
	wire wr_en      = awvalid && wvalid && !bvalid_r;
	wire wr_ok      = wr_en && known_addr(awaddr);
	wire wr_lane0   = wr_ok && wstrb[0];
	wire rd_en      = arvalid && !rvalid_r;
	assign awready  = wr_en;
	assign wready   = wr_en;
	assign arready  = rd_en;
	assign bvalid   = bvalid_r;
	assign bresp    = bresp_r;
	assign rvalid   = rvalid_r;
	assign rresp    = rresp_r;
	assign rdata    = rdata_r;

	// decoded register strobes
	wire wr_ctrl    = wr_lane0 && awaddr == OFS_CONTROL;
	wire wr_sel     = wr_lane0 && awaddr == OFS_REF_SEL
		&& !sync_unit_enable_r;
	wire push_wr    = wr_lane0 && awaddr == OFS_PUSH && wdata[PUSH_BIT];
	wire wr_ldval   = wr_ok && awaddr == OFS_LOAD_VAL;
	wire load_wr    = wr_lane0 && awaddr == OFS_LOAD_STB
		&& wdata[LOAD_STB_BIT];
	wire wr_cmpval  = wr_ok && awaddr == OFS_CMP_VAL;
	wire wr_cmplen  = wr_ok && awaddr == OFS_CMP_LEN;
	wire wr_irqen   = wr_lane0 && awaddr == OFS_IRQ_EN;
	wire pop_wr     = wr_lane0 && awaddr == OFS_EV_POP && wdata[POP_BIT];

	// byte-lane merge for full-word registers
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
		end
	endfunction

	// reference time base
	wire tick       = sync_unit_enable_r && selected_time_reference;
	wire cnt_inc_ok = tick && !load_wr;
	wire [31:0] cnt_plus = cnt_r + 32'h0000_0001;
	wire cmp_armed  = cmp_len_r != '0;
	wire cmp_hit    = cnt_inc_ok && cmp_armed && cnt_plus == cmp_val_r;
	wire roll_hit   = cnt_inc_ok && cnt_r == CNT_MAX;
	wire half_hit   = cnt_inc_ok && cnt_r == CNT_HALF;

	always_comb begin
		if (!sync_unit_enable_r)
			cnt_nxt = RST_ZERO;
		else if (load_wr)
			cnt_nxt = load_val_r;
		else if (tick)
			cnt_nxt = cnt_plus;
		else
			cnt_nxt = cnt_r;
	end

	always_comb begin
		if (!sync_unit_enable_r || !cmp_armed)
			pulse_cnt_nxt = '0;
		else if (cmp_hit)
			pulse_cnt_nxt = cmp_len_r;
		else if (tick && pulse_cnt_r != '0)
			pulse_cnt_nxt = pulse_cnt_r - 16'h0001;
		else
			pulse_cnt_nxt = pulse_cnt_r;
	end
	assign compare_output = pulse_cnt_r != '0;
	assign ref_clock_select = ref_sel_r;

	// event source selection, push first
	wire fifo_full  = count_r == (FIFO_AW+1)'(FIFO_DEPTH);
	wire fifo_empty = count_r == '0;
	wire ev_any     = push_wr || cmp_hit || roll_hit || half_hit;
	wire ev_wr      = ev_any && !fifo_full;
	wire [3:0] ev_type_sel = push_wr ? EV_PUSH :
		cmp_hit ? EV_COMPARE : roll_hit ? EV_ROLL : EV_HALF;
	wire [31:0] ev_stamp_sel = push_wr ? cnt_r :
		cmp_hit ? cmp_val_r : RST_ZERO;
	wire ev_pop     = pop_wr && !fifo_empty;
	assign count_nxt = count_r + (FIFO_AW+1)'(ev_wr)
		- (FIFO_AW+1)'(ev_pop);

	wire pending_raw    = !fifo_empty;
	wire pending_masked = pending_raw && irq_en_r;
	wire [31:0] head_low  = ev_stamp_mem[rd_ptr_r];
	wire [31:0] head_mid  = 32'(ev_type_mem[rd_ptr_r]) << EV_TYPE_LSB;
	wire [31:0] head_high = head_mid;

	// read decode; push and strobe read zero
	// load value readback
	logic [31:0] rd_mux;
	always_comb begin
		unique case (araddr)
			OFS_IDENT:      rd_mux = {UNIT_IDENT, RTL_REVISION,
				MAJOR_REVISION, MINOR_REVISION};
			OFS_CONTROL:    rd_mux = 32'(sync_unit_enable_r);
			OFS_REF_SEL:    rd_mux = 32'(ref_sel_r);
			OFS_LOAD_VAL:   rd_mux = load_val_r;
			OFS_CMP_VAL:    rd_mux = cmp_val_r;
			OFS_CMP_LEN:    rd_mux = 32'(cmp_len_r);
			OFS_IRQ_RAW:    rd_mux = 32'(pending_raw);
			OFS_IRQ_MASKED: rd_mux = 32'(pending_masked);
			OFS_IRQ_EN:     rd_mux = 32'(irq_en_r);
			OFS_EV_LOW:     rd_mux = fifo_empty ? RST_ZERO : head_low;
			OFS_EV_MID:     rd_mux = fifo_empty ? RST_ZERO : head_mid;
			OFS_EV_HIGH:    rd_mux = fifo_empty ? RST_ZERO : head_high;
			default:        rd_mux = RST_ZERO;
		endcase
	end

	// bus response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= RST_ZERO;
		end else begin
			if (wr_en) begin
				bvalid_r <= 1'b1;
				bresp_r  <= known_addr(awaddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (bready)
				bvalid_r <= 1'b0;
			if (rd_en) begin
				rvalid_r <= 1'b1;
				rresp_r  <= known_addr(araddr) ? RESP_OKAY : RESP_SLVERR;
				rdata_r  <= rd_mux;
			end else if (rready)
				rvalid_r <= 1'b0;
		end
	end

	// software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_unit_enable_r <= 1'b0;
			ref_sel_r          <= '0;
			load_val_r         <= RST_ZERO;
			cmp_val_r          <= RST_ZERO;
			cmp_len_r          <= '0;
			irq_en_r           <= 1'b0;
		end else begin
			if (wr_ctrl)
				sync_unit_enable_r <= wdata[CTRL_EN_BIT];
			if (wr_sel)
				ref_sel_r <= wdata[REF_SEL_W-1:0];
			if (wr_ldval)
				load_val_r <= merge(load_val_r, wdata, wstrb);
			if (wr_cmpval)
				cmp_val_r <= merge(cmp_val_r, wdata, wstrb);
			if (wr_cmplen)
				cmp_len_r <= CMP_LEN_W'(merge(32'(cmp_len_r), wdata, wstrb));
			if (wr_irqen)
				irq_en_r <= wdata[PEND_BIT];
		end
	end

	// single clock domain, tick is an enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r       <= RST_ZERO;
			pulse_cnt_r <= '0;
		end else begin
			cnt_r       <= cnt_nxt;
			pulse_cnt_r <= pulse_cnt_nxt;
		end
	end

	// event fifo pointers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (ev_wr)
				wr_ptr_r <= wr_ptr_r + FIFO_AW'(1);
			if (ev_pop)
				rd_ptr_r <= rd_ptr_r + FIFO_AW'(1);
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (ev_wr) begin
			ev_stamp_mem[wr_ptr_r] <= ev_stamp_sel;
			ev_type_mem[wr_ptr_r]  <= ev_type_sel;
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	push_stamp_a: assert property (
		push_wr && fifo_empty |=> pending_raw && head_low == $past(cnt_r)
			&& ev_type_mem[rd_ptr_r] == EV_PUSH)
		else $error("pushed event does not hold counter at write");
	load_copy_a: assert property (
		load_wr && sync_unit_enable_r |=> cnt_r == $past(load_val_r))
		else $error("load strobe did not copy load value");
	sel_lock_a: assert property (
		sync_unit_enable_r |=> $stable(ref_clock_select))
		else $error("select changed while unit enabled");
	disabled_reset_a: assert property (
		!sync_unit_enable_r |=> cnt_r == RST_ZERO && !compare_output)
		else $error("reference logic not held in reset");
	masked_pend_a: assert property (
		rd_en && araddr == OFS_IRQ_MASKED
			|=> rdata == {31'h0, $past(irq_en_r) && $past(pending_raw)})
		else $error("masked pending read mismatch");
	cmp_pulse_a: assert property (
		cmp_hit |=> compare_output && pulse_cnt_r == $past(cmp_len_r))
		else $error("compare pulse not started with length");
	len_zero_a: assert property (
		!cmp_armed |=> !compare_output)
		else $error("compare output with zero length");
	pop_adv_a: assert property (
		ev_pop && !ev_wr |=> count_r == $past(count_r) - 4'h1
			&& rd_ptr_r == $past(rd_ptr_r) + 3'h1)
		else $error("pop did not advance fifo");
	tick_count_a: assert property (
		cnt_inc_ok ##1 !load_wr && sync_unit_enable_r
			|-> cnt_r == $past(cnt_r) + 32'h1)
		else $error("counter did not increment");
	bresp_hold_a: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");

	push_seen_c: cover property (push_wr ##1 pending_raw);
	cmp_seen_c:  cover property (cmp_hit ##1 compare_output [*2]);
	full_seen_c: cover property (fifo_full);
	pop_seen_c:  cover property (ev_pop);

endmodule

//--- verification/time_sync_timestamp_unit_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH %0t %s", $time, m); end end
module time_sync_timestamp_unit_tb_top;
	import time_sync_pkg::*;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        selected_time_reference;
	logic [4:0]  ref_clock_select;
	logic        compare_output;
	logic [31:0] d;
	logic [1:0]  r;
	int          hi;
	int          errors;
	int          n_tests;
	int          cycles;

	time_sync_timestamp_unit i_time_sync_timestamp_unit (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.selected_time_reference(selected_time_reference),
		.ref_clock_select(ref_clock_select),
		.compare_output(compare_output)
	);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] v);
		wr(a, v);
		`CHK(r, RESP_OKAY, "bresp")
	endtask

	task automatic cr(input logic [7:0] a, input logic [31:0] x, string m);
		rd(a);
		`CHK(r, RESP_OKAY, "rresp")
		`CHK(d, x, m)
	endtask

	// n reference ticks, counting cycles with the compare pin high
	task automatic tk(input int n);
		hi = 0;
		@(posedge aclk);
		selected_time_reference <= 1'b1;
		repeat (n) begin
			@(posedge aclk);
			if (compare_output === 1'b1)
				hi++;
		end
		selected_time_reference <= 1'b0;
	endtask

	task automatic t_regs();
		cr(OFS_IDENT, {UNIT_IDENT, RTL_REVISION, MAJOR_REVISION,
			MINOR_REVISION}, "ident");
		cr(OFS_CMP_VAL, RST_ZERO, "cmp rst");
		cr(OFS_IRQ_RAW, RST_ZERO, "raw rst");
		cr(OFS_EV_LOW, RST_ZERO, "empty low");
		wr(8'h2c, CNT_MAX);
		`CHK(r, RESP_SLVERR, "gap wr")
		rd(8'h40);
		`CHK(r, RESP_SLVERR, "gap rd")
		$display("test regs done");
	endtask

	task automatic t_select();
		w(OFS_REF_SEL, 32'hffff_ffe5);
		`CHK(ref_clock_select, 5'h05, "sel pin")
		cr(OFS_REF_SEL, 32'h5, "sel rd");
		w(OFS_CONTROL, 32'h1);
		w(OFS_REF_SEL, 32'h1f);
		`CHK(ref_clock_select, 5'h05, "sel locked")
		w(OFS_CONTROL, 32'h0);
		w(OFS_REF_SEL, 32'h1f);
		`CHK(ref_clock_select, 5'h1f, "sel free")
		$display("test select done");
	endtask

	task automatic t_push();
		w(OFS_CONTROL, 32'h1);
		w(OFS_LOAD_VAL, 32'ha5c3_0f10);
		w(OFS_LOAD_STB, 32'h1);
		cr(OFS_LOAD_VAL, 32'ha5c3_0f10, "load rd");
		cr(OFS_LOAD_STB, RST_ZERO, "stb rd");
		w(OFS_PUSH, 32'h1);
		cr(OFS_PUSH, RST_ZERO, "push rd");
		tk(5);
		cr(OFS_IRQ_RAW, 32'h1, "raw set");
		cr(OFS_IRQ_MASKED, 32'h0, "masked off");
		w(OFS_IRQ_EN, 32'h1);
		cr(OFS_IRQ_MASKED, 32'h1, "masked on");
		cr(OFS_EV_LOW, 32'ha5c3_0f10, "push stamp");
		rd(OFS_EV_MID);
		`CHK(d[EV_TYPE_LSB +: EV_TYPE_W], EV_PUSH, "push type")
		cr(OFS_EV_HIGH, 32'(EV_PUSH) << EV_TYPE_LSB, "high word");
		w(OFS_EV_POP, 32'h1);
		cr(OFS_IRQ_RAW, 32'h0, "raw clr");
		w(OFS_PUSH, 32'h1);
		cr(OFS_EV_LOW, 32'ha5c3_0f15, "count up");
		w(OFS_EV_POP, 32'h1);
		$display("test push done");
	endtask

	task automatic t_cmp();
		// length cleared before the value changes
		w(OFS_CMP_LEN, 32'h0);
		w(OFS_CMP_VAL, 32'h0000_1234);
		w(OFS_LOAD_VAL, 32'h0000_1232);
		w(OFS_LOAD_STB, 32'h1);
		tk(10);
		`CHK(hi, 0, "len0 pin")
		cr(OFS_IRQ_RAW, 32'h0, "len0 event");
		w(OFS_LOAD_STB, 32'h1);
		w(OFS_CMP_LEN, 32'h3);
		tk(10);
		`CHK(hi, 3, "pulse len")
		w(OFS_PUSH, 32'h1);
		cr(OFS_EV_LOW, 32'h0000_1234, "cmp stamp");
		rd(OFS_EV_MID);
		`CHK(d[EV_TYPE_LSB +: EV_TYPE_W], EV_COMPARE, "cmp type")
		w(OFS_EV_POP, 32'h1);
		cr(OFS_EV_LOW, 32'h0000_123c, "next head");
		w(OFS_EV_POP, 32'h1);
		$display("test compare done");
	endtask

	task automatic t_roll();
		w(OFS_LOAD_VAL, 32'h7fff_fffe);
		w(OFS_LOAD_STB, 32'h1);
		tk(2);
		rd(OFS_EV_MID);
		`CHK(d[EV_TYPE_LSB +: EV_TYPE_W], EV_HALF, "half type")
		w(OFS_EV_POP, 32'h1);
		w(OFS_LOAD_VAL, CNT_MAX - 32'h1);
		w(OFS_LOAD_STB, 32'h1);
		tk(2);
		rd(OFS_EV_MID);
		`CHK(d[EV_TYPE_LSB +: EV_TYPE_W], EV_ROLL, "roll type")
		w(OFS_EV_POP, 32'h1);
		$display("test rollover done");
	endtask

	task automatic t_dis();
		// start a pulse and leave it standing, then disable
		w(OFS_LOAD_VAL, 32'h0000_1232);
		w(OFS_LOAD_STB, 32'h1);
		tk(2);
		cr(OFS_IRQ_RAW, 32'h1, "cmp pend");
		`CHK(compare_output, 1'b1, "pin held")
		w(OFS_EV_POP, 32'h1);
		w(OFS_CONTROL, 32'h0);
		cr(OFS_CONTROL, RST_ZERO, "ctl off");
		`CHK(compare_output, 1'b0, "pin off")
		tk(4);
		w(OFS_PUSH, 32'h1);
		cr(OFS_EV_LOW, RST_ZERO, "held reset");
		w(OFS_EV_POP, 32'h1);
		$display("test disable done");
	endtask

	initial begin
		errors = 0;
		n_tests = 0;
		cycles = 0;
		aresetn = 1'b0;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready, selected_time_reference} = '0;
		wstrb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_select();
		t_push();
		t_cmp();
		t_roll();
		t_dis();
		results();
	end
endmodule
